// >>> hw/pwmc_channel.sv
/*
  One timer channel measuring the high or low width of an input signal,
  with its unit clock enable, count clock prescaler and APB register file.
  Assumes pclk at 20 MHz, an APB master on the same clock and asynchronous
  pin inputs, which are synchronised here before use.
*/
// Design decisions made here: the APB register port and the register addresses.
// How it works
// - Width equals count period times overflow times 10000H plus capture plus one.
// - The input is sampled on the channel's selected operating clock tick.
// - Counter counts up; start trigger sets enable status and waits for start edge.
// - On the start edge the counter restarts from 0000H on count ticks.
// - High width starts rising, captures falling; low width is the reverse.
// - On the capture edge the count goes to the data register with an interrupt.
// - Each capture sets the overflow flag if the counter wrapped, else clears it.
// - After capture the counter holds capture plus one and waits for a new start.
// - Several overflows still only set the overflow flag to one.
// - Edge select 10B measures low width, 11B measures high width.
// - Without the unit clock enable, writes other than to the unit enable are ignored; channel stays stopped.
// - The clock select register sets the four selectable count clock rates.
// - The master select bit exists only on channels 2, 4 and 6.
// - The start trigger clears itself after being written with one.
// - Stop trigger clears enable status, halts counting, keeps counter and overflow.
`timescale 1ns/100ps
module pwmc_channel
  import pwmc_pkg::*;
#(
  parameter int CHANNEL_ID = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  input wire logic uart_receive_line,
  output logic channel_interrupt
);

  // Channels outside 0..7 do not exist in the unit.
  if (CHANNEL_ID < 0 || CHANNEL_ID > 7) begin : g_bad_channel
    $error("pwmc_channel: CHANNEL_ID must lie in 0..7");
  end

  // The clock select fields and the mode layout must each fill one 16-bit field.
  if ((PWMC_NUM_CLK * PWMC_SEL_W != PWMC_CNT_W) ||
      ($bits(pwmc_mode_s) != PWMC_CNT_W)) begin : g_bad_layout
    $error("pwmc_channel: clock select and mode layouts must be 16 bits wide");
  end

  localparam bit HAS_MASTER = (CHANNEL_ID == 2) || (CHANNEL_ID == 4) || (CHANNEL_ID == 6);

  // Decodes whether an offset belongs to the register map.
  function automatic logic pwmc_mapped(input logic [7:0] ofs);
    case (ofs)
      PWMC_OFS_UNIT_EN, PWMC_OFS_CLK_SEL, PWMC_OFS_MODE, PWMC_OFS_START,
      PWMC_OFS_STOP, PWMC_OFS_EN_STAT, PWMC_OFS_COUNTER, PWMC_OFS_DATA,
      PWMC_OFS_STATUS, PWMC_OFS_IN_SWITCH: pwmc_mapped = 1'b1;
      default: pwmc_mapped = 1'b0;
    endcase
  endfunction : pwmc_mapped

  // These hold the state of the channel and its register file.
  logic unit_en_ff;
  logic [15:0] clk_sel_ff;
  pwmc_mode_s mode_ff;
  logic lin_input_switch_bit_ff;
  logic channel_enable_status_ff;
  pwmc_state_e state_ff;
  logic [15:0] channel_counter_ff;
  logic [15:0] channel_data_register_ff;
  logic overflow_flag_ff;
  logic ovf_seen_ff;
  logic channel_interrupt_ff;
  logic [15:0] prescale_ff;
  logic [1:0] pin_sync_ff;
  logic [1:0] rxd_sync_ff;
  logic sample_ff;
  logic sample_prev_ff;
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  // These are decoded from the state and the bus in every cycle.
  logic [PWMC_NUM_CLK-1:0] clk_tick;
  logic op_tick;
  logic wr_fire;
  logic start_wr;
  logic stop_wr;
  logic rise_edge;
  logic fall_edge;
  logic start_edge;
  logic capture_edge;
  logic measure_on;
  logic [31:0] nxt_rdata;
  pwmc_mode_s wr_mode;
  logic meas_in;

  // Completing APB write; writes other than the unit enable need the unit clock.
  assign wr_fire = psel && penable && pready_ff && pwrite;
  assign start_wr = wr_fire && unit_en_ff && (paddr == PWMC_OFS_START) &&
                    pwdata[PWMC_BIT_TRIGGER];
  assign stop_wr = wr_fire && unit_en_ff && (paddr == PWMC_OFS_STOP) &&
                   pwdata[PWMC_BIT_TRIGGER];

  // Write data seen through the mode layout, so no bit position is spelled out.
  assign wr_mode = pwdata[PWMC_CNT_W-1:0];

  // Peripheral clock enable of the unit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_en_ff <= 1'b0;
    end else if (wr_fire && paddr == PWMC_OFS_UNIT_EN) begin
      unit_en_ff <= pwdata[PWMC_BIT_UNIT_EN];
    end
  end

  // Configuration registers; they return to reset values while the unit is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_ff <= PWMC_CLK_SEL_RST;
      mode_ff <= PWMC_MODE_RST;
      lin_input_switch_bit_ff <= 1'b0;
    end else if (!unit_en_ff) begin
      clk_sel_ff <= PWMC_CLK_SEL_RST;
      mode_ff <= PWMC_MODE_RST;
      lin_input_switch_bit_ff <= 1'b0;
    end else if (wr_fire) begin
      if (paddr == PWMC_OFS_CLK_SEL) begin
        clk_sel_ff <= pwdata[15:0];
      end
      if (paddr == PWMC_OFS_MODE) begin
        mode_ff <= wr_mode;
        mode_ff.rsvd_a <= '0;
        mode_ff.rsvd_b <= '0;
        mode_ff.rsvd_c <= '0;
        mode_ff.master_select_bit <= HAS_MASTER && wr_mode.master_select_bit;
      end
      if (paddr == PWMC_OFS_IN_SWITCH) begin
        lin_input_switch_bit_ff <= pwdata[PWMC_BIT_LIN_SW];
      end
    end
  end

  // Free running prescaler; it only runs while the unit receives its clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_ff <= PWMC_CNT_ZERO;
    end else if (!unit_en_ff) begin
      prescale_ff <= PWMC_CNT_ZERO;
    end else begin
      prescale_ff <= prescale_ff + PWMC_PRE_ONE;
    end
  end

  // Each selectable count clock ticks once every 2**field pclk cycles.
  for (genvar k = 0; k < PWMC_NUM_CLK; k++) begin : g_tick
    logic [15:0] mask;
    assign mask = (PWMC_PRE_ONE << clk_sel_ff[k*PWMC_SEL_W +: PWMC_SEL_W]) - PWMC_PRE_ONE;
    assign clk_tick[k] = unit_en_ff && ((prescale_ff & mask) == mask);
  end

  assign op_tick = clk_tick[mode_ff.channel_clock_select];

  // Two-stage synchronisers for both candidate inputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_ff <= 2'h0;
      rxd_sync_ff <= 2'h0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[0], timer_input_pin};
      rxd_sync_ff <= {rxd_sync_ff[0], uart_receive_line};
    end
  end

  // Source of the measured signal; only the second synchroniser stages are read.
  assign meas_in = lin_input_switch_bit_ff ? rxd_sync_ff[1] : pin_sync_ff[1];

  // The measured signal is sampled only on the operating clock, which costs up
  // to one operating clock of accuracy but keeps edges aligned to count ticks.
  // While the unit is off both samples follow the input, so enabling makes no edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_ff <= 1'b0;
      sample_prev_ff <= 1'b0;
    end else if (!unit_en_ff) begin
      sample_ff <= meas_in;
      sample_prev_ff <= meas_in;
    end else if (op_tick) begin
      sample_ff <= meas_in;
      sample_prev_ff <= sample_ff;
    end
  end

  // Edge decode; only edge select 1x is a width measurement.
  assign rise_edge = sample_ff && !sample_prev_ff;
  assign fall_edge = !sample_ff && sample_prev_ff;
  assign measure_on = mode_ff.edge_select_hi;
  assign start_edge = op_tick && measure_on &&
                      (mode_ff.edge_select_lo ? rise_edge : fall_edge);
  assign capture_edge = op_tick && measure_on &&
                        (mode_ff.edge_select_lo ? fall_edge : rise_edge);

  // Enable status: the trigger bits are not stored, so they read back as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_status_ff <= 1'b0;
    end else if (!unit_en_ff || stop_wr) begin
      channel_enable_status_ff <= 1'b0;
    end else if (start_wr) begin
      channel_enable_status_ff <= 1'b1;
    end
  end

  // Channel sequence; a start while enabled is ignored rather than restarting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= PWMC_ST_STOPPED;
    end else if (!unit_en_ff || stop_wr) begin
      state_ff <= PWMC_ST_STOPPED;
    end else begin
      case (state_ff)
        PWMC_ST_STOPPED: begin
          if (start_wr) begin
            state_ff <= PWMC_ST_WAIT_START;
          end
        end
        PWMC_ST_WAIT_START: begin
          if (start_edge) begin
            state_ff <= PWMC_ST_MEASURE;
          end
        end
        PWMC_ST_MEASURE: begin
          if (capture_edge) begin
            state_ff <= PWMC_ST_WAIT_START;
          end
        end
        default: begin
          state_ff <= PWMC_ST_STOPPED;
        end
      endcase
    end
  end

  // Up-counter: cleared at the start edge, counts ticks, holds while waiting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_counter_ff <= PWMC_CNT_ZERO;
    end else if (!unit_en_ff) begin
      channel_counter_ff <= PWMC_CNT_ZERO;
    end else if (stop_wr) begin
      channel_counter_ff <= channel_counter_ff;
    end else if (state_ff == PWMC_ST_WAIT_START && start_edge) begin
      channel_counter_ff <= PWMC_CNT_ZERO;
    end else if (state_ff == PWMC_ST_MEASURE && op_tick) begin
      channel_counter_ff <= channel_counter_ff + PWMC_CNT_ONE;
    end
  end

  // Overflow seen during the current measurement; sticky, so repeated wraps
  // collapse into one and the width becomes ambiguous.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_seen_ff <= 1'b0;
    end else if (!unit_en_ff) begin
      ovf_seen_ff <= 1'b0;
    end else if (state_ff == PWMC_ST_WAIT_START && start_edge) begin
      ovf_seen_ff <= 1'b0;
    end else if (state_ff == PWMC_ST_MEASURE && op_tick && !capture_edge &&
                 channel_counter_ff == PWMC_CNT_MAX) begin
      ovf_seen_ff <= 1'b1;
    end
  end

  // Capture of count and overflow; width = tick*(ovf*10000H + data + 1).
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_data_register_ff <= PWMC_CNT_ZERO;
      overflow_flag_ff <= 1'b0;
    end else if (!unit_en_ff) begin
      channel_data_register_ff <= PWMC_CNT_ZERO;
      overflow_flag_ff <= 1'b0;
    end else if (!stop_wr && state_ff == PWMC_ST_MEASURE && capture_edge) begin
      channel_data_register_ff <= channel_counter_ff;
      overflow_flag_ff <= ovf_seen_ff;
    end
  end

  // Interrupt pulse raised the cycle after the capture edge, one pclk long.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_interrupt_ff <= 1'b0;
    end else begin
      channel_interrupt_ff <= unit_en_ff && !stop_wr && state_ff == PWMC_ST_MEASURE &&
                              capture_edge;
    end
  end

  assign channel_interrupt = channel_interrupt_ff;

  // Read multiplexer; reserved bits read as zero.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      PWMC_OFS_UNIT_EN: nxt_rdata[PWMC_BIT_UNIT_EN] = unit_en_ff;
      PWMC_OFS_CLK_SEL: nxt_rdata[15:0] = clk_sel_ff;
      PWMC_OFS_MODE: nxt_rdata[15:0] = mode_ff;
      PWMC_OFS_EN_STAT: nxt_rdata[PWMC_BIT_EN_STAT] = channel_enable_status_ff;
      PWMC_OFS_COUNTER: nxt_rdata[15:0] = channel_counter_ff;
      PWMC_OFS_DATA: nxt_rdata[15:0] = channel_data_register_ff;
      PWMC_OFS_STATUS: nxt_rdata[PWMC_BIT_OVF] = overflow_flag_ff;
      PWMC_OFS_IN_SWITCH: nxt_rdata[PWMC_BIT_LIN_SW] = lin_input_switch_bit_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // One wait state per access so read data comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
      prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
      pslverr_ff <= !pwmc_mapped(paddr);
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign pready = pready_ff;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

endmodule : pwmc_channel

// >>> shared/pwmc_pkg.sv
/*
  Package for the pulse width measurement channel: register map, field
  positions, reset values, the mode register layout and the channel states.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package pwmc_pkg;

  // Register byte offsets.
  localparam logic [7:0] PWMC_OFS_UNIT_EN = 8'h00;
  localparam logic [7:0] PWMC_OFS_CLK_SEL = 8'h04;
  localparam logic [7:0] PWMC_OFS_MODE = 8'h08;
  localparam logic [7:0] PWMC_OFS_START = 8'h0c;
  localparam logic [7:0] PWMC_OFS_STOP = 8'h10;
  localparam logic [7:0] PWMC_OFS_EN_STAT = 8'h14;
  localparam logic [7:0] PWMC_OFS_COUNTER = 8'h18;
  localparam logic [7:0] PWMC_OFS_DATA = 8'h1c;
  localparam logic [7:0] PWMC_OFS_STATUS = 8'h20;
  localparam logic [7:0] PWMC_OFS_IN_SWITCH = 8'h24;

  // Field positions.
  localparam int PWMC_BIT_UNIT_EN = 0;
  localparam int PWMC_BIT_TRIGGER = 0;
  localparam int PWMC_BIT_EN_STAT = 0;
  localparam int PWMC_BIT_OVF = 0;
  localparam int PWMC_BIT_LIN_SW = 1;
  localparam int PWMC_SEL_W = 4;
  localparam int PWMC_NUM_CLK = 4;
  localparam int PWMC_CNT_W = 16;

  // Reset and constant values.
  localparam logic [15:0] PWMC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] PWMC_CNT_ONE = 16'h0001;
  localparam logic [15:0] PWMC_CNT_MAX = 16'hffff;
  localparam logic [15:0] PWMC_PRE_ONE = 16'h0001;
  localparam logic [15:0] PWMC_CLK_SEL_RST = 16'h0000;

  // Mode register layout, bits 15..0 of the word.
  typedef struct packed {
    logic [1:0] channel_clock_select;  // Bits 15:14.
    logic [1:0] rsvd_a;
    logic master_select_bit;           // Bit 11.
    logic [2:0] rsvd_b;
    logic edge_select_hi;              // Bit 7.
    logic edge_select_lo;              // Bit 6.
    logic [5:0] rsvd_c;
  } pwmc_mode_s;

  localparam pwmc_mode_s PWMC_MODE_RST = '0;

  typedef enum logic [1:0] {
    PWMC_ST_STOPPED,
    PWMC_ST_WAIT_START,
    PWMC_ST_MEASURE
  } pwmc_state_e;

endpackage : pwmc_pkg

// >>> verification/pwmc_channel_props.sv
/*
  Port checker for the pulse width channel.
  Assumes it is bound into every pwmc_channel instance.
*/
`timescale 1ns/100ps
module pwmc_channel_props
  import pwmc_pkg::*;
#(
  parameter int CHANNEL_ID = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_input_pin,
  input wire logic uart_receive_line,
  input wire logic channel_interrupt
);
  logic rd_ok;
  logic wr_ok;
  logic en_ff;
  logic unit_ff;
  // A transfer completes at the edge where pready is sampled high.
  assign rd_ok = psel && penable && pready && !pwrite;
  assign wr_ok = psel && penable && pready && pwrite;
  // Shadow of unit enable and run state; writes while off are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 1'b0;
      unit_ff <= 1'b0;
    end else if (wr_ok && paddr == PWMC_OFS_UNIT_EN) begin
      unit_ff <= pwdata[0];
      en_ff <= en_ff && pwdata[0];
    end else if (wr_ok && unit_ff && pwdata[0]) begin
      if (paddr == PWMC_OFS_START) en_ff <= 1'b1;
      if (paddr == PWMC_OFS_STOP) en_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_irq_pulse: assert property (channel_interrupt |=> !channel_interrupt)
    else $error("interrupt longer than one cycle");
  chk_irq_running: assert property (channel_interrupt |-> en_ff || $past(en_ff))
    else $error("interrupt while channel stopped");
  chk_irq_unit_on: assert property (channel_interrupt |-> unit_ff)
    else $error("interrupt while unit disabled");
  chk_start_clear: assert property (rd_ok && paddr == PWMC_OFS_START |-> prdata == 32'h0)
    else $error("start trigger reads nonzero");
  chk_master_fixed: assert property (rd_ok && paddr == PWMC_OFS_MODE &&
    (CHANNEL_ID == 0 || CHANNEL_ID == 5 || CHANNEL_ID == 7) |-> !prdata[11])
    else $error("master select set on fixed channel");
  chk_en_mirror: assert property (rd_ok && paddr == PWMC_OFS_EN_STAT |-> prdata == {31'h0, en_ff})
    else $error("enable status wrong");
  chk_ovf_field: assert property (rd_ok && paddr == PWMC_OFS_STATUS |-> prdata[31:1] == 31'h0)
    else $error("status upper bits set");
  chk_cnt_width: assert property (rd_ok && (paddr == PWMC_OFS_COUNTER ||
    paddr == PWMC_OFS_DATA) |-> prdata[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  cov_irq: cover property (channel_interrupt);
  cov_err: cover property (pslverr);
  cov_ovf: cover property (rd_ok && paddr == PWMC_OFS_STATUS && prdata[0]);
endmodule : pwmc_channel_props
bind pwmc_channel pwmc_channel_props #(.CHANNEL_ID(CHANNEL_ID)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_input_pin(timer_input_pin), .uart_receive_line(uart_receive_line),
  .channel_interrupt(channel_interrupt));

// >>> verification/pwmc_channel_tb.sv
/*
  Self-checking bench for the pulse width channel over APB.
  Assumes the pulse source model and the bound checker.
*/
`timescale 1ns/100ps
module pwmc_channel_tb
  import pwmc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic fire = 1'b0;
  logic lvl = 1'b1;
  logic lin = 1'b0;
  logic [16:0] width = 17'h0;
  logic sig;
  int err_total = 0;
  int cmp_count = 0;
  // A 50 ns clock; channel 5 has no master select bit.
  always #25 pclk = ~pclk;
  pwmc_channel #(.CHANNEL_ID(5)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_pin(lin ? 1'b0 : sig),
    .uart_receive_line(lin ? sig : 1'b1), .channel_interrupt(irq));
  pwmc_pulse_src u_src (.pclk(pclk), .presetn(presetn), .fire(fire), .lvl(lvl),
    .width(width), .sig(sig));
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One transfer; starts on a fresh edge so signals are never driven twice.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    check({31'h0, e}, 32'h0);
  endtask : wr
  // Only the spare address 28h may answer with an error.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, a == 8'h28});
  endtask : rd
  // One pulse of w cycles; the interrupt wait is bounded by lim.
  task automatic meas(input logic [16:0] w, input int lim, input logic hit);
    int n;
    @(posedge pclk);
    width <= w;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, irq === 1'b1}, {31'h0, hit});
    if (hit && irq !== 1'b1) finish_test();
  endtask : meas
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(PWMC_OFS_EN_STAT, 32'h0);
    wr(PWMC_OFS_MODE, 32'hc0);
    rd(PWMC_OFS_MODE, 32'h0);
    rd(8'h28, 32'h0);
    wr(PWMC_OFS_UNIT_EN, 32'h1);
    wr(PWMC_OFS_MODE, 32'h8c0);
    rd(PWMC_OFS_MODE, 32'hc0);
    rd(PWMC_OFS_EN_STAT, 32'h0);
    wr(PWMC_OFS_START, 32'h1);
    rd(PWMC_OFS_START, 32'h0);
    rd(PWMC_OFS_EN_STAT, 32'h1);
    meas(17'd20, 100, 1'b1);
    rd(PWMC_OFS_DATA, 32'd19);
    rd(PWMC_OFS_COUNTER, 32'd20);
    rd(PWMC_OFS_STATUS, 32'h0);
    meas(17'd65541, 66000, 1'b1);
    rd(PWMC_OFS_DATA, 32'd4);
    rd(PWMC_OFS_STATUS, 32'h1);
    wr(PWMC_OFS_STOP, 32'h1);
    rd(PWMC_OFS_EN_STAT, 32'h0);
    meas(17'd8, 100, 1'b0);
    rd(PWMC_OFS_COUNTER, 32'd5);
    rd(PWMC_OFS_STATUS, 32'h1);
    lvl <= 1'b0;
    wr(PWMC_OFS_MODE, 32'h80);
    wr(PWMC_OFS_START, 32'h1);
    meas(17'd30, 100, 1'b1);
    rd(PWMC_OFS_DATA, 32'd29);
    rd(PWMC_OFS_STATUS, 32'h0);
    wr(PWMC_OFS_STOP, 32'h1);
    lvl <= 1'b1;
    wr(PWMC_OFS_CLK_SEL, 32'h20);
    wr(PWMC_OFS_MODE, 32'h40c0);
    wr(PWMC_OFS_START, 32'h1);
    meas(17'd40, 200, 1'b1);
    rd(PWMC_OFS_DATA, 32'd9);
    wr(PWMC_OFS_STOP, 32'h1);
    lin <= 1'b1;
    wr(PWMC_OFS_IN_SWITCH, 32'h2);
    wr(PWMC_OFS_CLK_SEL, 32'h0);
    wr(PWMC_OFS_MODE, 32'hc0);
    wr(PWMC_OFS_START, 32'h1);
    meas(17'd12, 100, 1'b1);
    rd(PWMC_OFS_DATA, 32'd11);
    // Edge select 01B measures nothing, so a pulse must raise no interrupt.
    wr(PWMC_OFS_STOP, 32'h1);
    wr(PWMC_OFS_MODE, 32'h40);
    wr(PWMC_OFS_START, 32'h1);
    meas(17'd12, 100, 1'b0);
    rd(PWMC_OFS_EN_STAT, 32'h1);
    // Turning the unit off must return the data, enable status and input switch registers to reset.
    wr(PWMC_OFS_UNIT_EN, 32'h0);
    rd(PWMC_OFS_DATA, 32'h0);
    rd(PWMC_OFS_EN_STAT, 32'h0);
    rd(PWMC_OFS_IN_SWITCH, 32'h0);
    finish_test();
  end
endmodule : pwmc_channel_tb

// >>> verification/pwmc_pulse_src.sv
/*
  Model of the external pulse source on the measured input.
  Assumes fire is a one-cycle request and lvl is the active level.
*/
`timescale 1ns/100ps
module pwmc_pulse_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic lvl,
  input wire logic [16:0] width,
  output logic sig
);
  logic [16:0] left_ff;
  // Count down the active phase of one pulse, width pclk cycles long.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 17'h00000;
    end else if (fire) begin
      left_ff <= width;
    end else if (left_ff != 17'h00000) begin
      left_ff <= left_ff - 17'h00001;
    end
  end
  // Idle level is the inverse, so each pulse makes a start and a capture edge.
  assign sig = (left_ff != 17'h00000) ? lvl : !lvl;
endmodule : pwmc_pulse_src
